// ==== design/lifd_pkg.sv ====
// Overview of operation
// - transmit function when address line fifteen high and fourteen low
// - dataset-off function when lines fourteen and fifteen high, twelve low
// - address line thirteen picks send module versus receive module
// - status enable active low when controller match, unit selected, no reset
// - return inverted carry and overflow status bits from interface module
// - shift-up character (bits 1,2,4,5 set, bit 3 clear) sets case flop
// - receive service request cleared when receive data taken
// - one of eight receivers picked by unit select and 3-bit address, true and inverted
// - stop enable term from address line fourteen, with duplicate copy
// - eight send data lines conveyed from controller to send module
// - accept 8 received bits, long space pulse and active-low service request
// - per-line send strobe is function strobe gated with send enable
// - active-low presence lines mark installed send and receive modules
// - four receive clocks and four send clocks, one per format group
// - receive modules 0..7 selected individually by write-direct instruction
// - controller match only when address equals switches and mode is 3
package lifd_pkg;
  // ----------------------------------------------------------------
  // register map
  // ----------------------------------------------------------------
  localparam logic [11:0] LIFD_CTRL_ADDR = 12'h000;
  localparam logic [11:0] LIFD_SEND_ADDR = 12'h004;
  localparam logic [11:0] LIFD_STAT_ADDR = 12'h008;
  localparam logic [11:0] LIFD_RECV_ADDR = 12'h00c;
  localparam logic [11:0] LIFD_PRES_ADDR = 12'h010;
  // ctrl register fields
  localparam int LIFD_CTRL_SWITCH_LSB = 0;
  localparam int LIFD_CTRL_CASE_CLR = 8;
  localparam logic [31:0] LIFD_CTRL_RESET = 32'h0000_0000;
  // ----------------------------------------------------------------
  // bus and line constants
  // ----------------------------------------------------------------
  localparam logic [1:0] LIFD_MODE_MATCH = 2'h3;
  localparam int LIFD_LINES = 8;
  localparam int LIFD_FIFO_DEPTH = 16;
  localparam int LIFD_DATA_W = 8;
  localparam int LIFD_FMTS = 4;
  typedef enum logic [1:0] {
    LIFD_IDLE = 2'b00,
    LIFD_SEND = 2'b01,
    LIFD_HOLD = 2'b10
  } lifd_state_t;
endpackage

// ==== design/lifd_fifo.sv ====
`timescale 1ns/100ps
`default_nettype none
module lifd_fifo #(
  parameter int WIDTH = 8,
  parameter int DEPTH = 16
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic in_valid,
  output logic in_ready,
  input wire logic [WIDTH-1:0] in_data,
  output logic out_valid,
  input wire logic out_ready,
  output logic [WIDTH-1:0] out_data
);
  localparam int AW = $clog2(DEPTH);
  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wp, rp, next_wp, next_rp;
  logic [AW:0] cnt, next_cnt;
  logic push, pop;
  assign in_ready = (cnt != DEPTH[AW:0]);
  assign out_valid = (cnt != '0);
  assign out_data = mem[rp];
  assign push = ce && in_valid && in_ready;
  assign pop = ce && out_valid && out_ready;
  always_comb begin
    next_wp = push ? AW'(wp + 1'b1) : wp;
    next_rp = pop ? AW'(rp + 1'b1) : rp;
    next_cnt = (AW+1)'(cnt + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop});
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      wp <= '0;
      rp <= '0;
      cnt <= '0;
    end else begin
      wp <= next_wp;
      rp <= next_rp;
      cnt <= next_cnt;
    end
  end
  // storage holds no reset; out_data is masked by out_valid downstream
  always_ff @(posedge pclk) begin
    if (push) begin
      mem[wp] <= in_data;
    end
  end
endmodule // lifd_fifo
`default_nettype wire

// ==== design/lifd_top.sv ====
`timescale 1ns/100ps
`default_nettype none
module lifd_top (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [7:0] bus_addr,
  input wire logic [1:0] bus_mode,
  input wire logic unit_addr_sel,
  input wire logic ctrl_reset_term,
  input wire logic addr_line_twelve_buf,
  input wire logic addr_line_thirteen_buf,
  input wire logic addr_line_fourteen_buf,
  input wire logic addr_line_fifteen_buf,
  input wire logic func_strobe,
  input wire logic send_enable_term,
  input wire logic [2:0] send_line_addr,
  input wire logic [2:0] recv_addr,
  input wire logic [2:0] recv_addr_n,
  input wire logic unit_recv_sel,
  input wire logic [7:0] send_data_in,
  input wire logic send_data_valid,
  output logic send_data_ready,
  output logic [7:0] send_data_lines,
  output logic send_data_out_valid,
  input wire logic [7:0] recv_data_in,
  input wire logic long_space_pulse,
  input wire logic recv_service_req_n,
  input wire logic recv_data_taken,
  input wire logic carry_in_n,
  input wire logic overflow_in_n,
  input wire logic [7:0] recv_present_n,
  input wire logic [7:0] send_present_n,
  input wire logic [3:0] recv_clk_fmt_in,
  input wire logic [3:0] send_clk_fmt_in,
  input wire logic one_mhz_clk_in,
  output logic one_mhz_clk_buf,
  output logic [3:0] recv_clk_fmt,
  output logic [3:0] send_clk_fmt,
  output logic xmit_func,
  output logic xmit_func_dup,
  output logic dataset_off_func,
  output logic dataset_off_func_dup,
  output logic send_or_recv_sel,
  output logic stop_enable_term,
  output logic stop_enable_term_dup,
  output logic status_en_n,
  output logic ctrl_addr_match,
  output logic reset_combined_n,
  output logic carry_status_n,
  output logic overflow_status_n,
  output logic shift_up_detect,
  output logic case_flop,
  output logic recv_service_pending,
  output logic long_space_seen,
  output logic [7:0] recv_data_reg,
  output logic [7:0] line_send_strobe,
  output logic [7:0] recv_module_sel,
  output logic [7:0] send_module_sel,
  output logic [7:0] recv_installed,
  output logic [7:0] send_installed
);
  import lifd_pkg::*;

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [7:0] lifd_onehot(input logic en, input logic [2:0] a,
                                             input logic [2:0] a_n);
    logic [7:0] r;
    r = 8'h00;
    for (int i = 0; i < LIFD_LINES; i++) begin
      r[i] = en && (a == 3'(i)) && (a_n == ~3'(i));
    end
    return r;
  endfunction

  // offsets compare on the full word address; unmapped offsets miss every hit
  function automatic logic lifd_reg_hit(input logic [11:0] a, input logic [11:0] offs);
    return a == offs;
  endfunction

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  logic [7:0] addr_switches, next_addr_switches;
  logic case_clr_req;
  logic [7:0] send_reg, next_send_reg;
  logic send_ld;
  logic next_case, next_pending, next_lsp;
  logic [7:0] next_recv_data;
  logic [7:0] next_recv_sel, next_send_sel;
  logic func_active;
  logic [31:0] next_prdata;
  logic wr_en, rd_en;
  logic ctrl_wr, recv_rd;
  logic fifo_out_valid;
  logic [7:0] fifo_out_data;
  lifd_state_t st, next_st;

  // every access completes without wait states; unmapped offsets read zero
  // and take no write, so no error response is ever raised
  assign pready = 1'b1;
  assign pslverr = 1'b0;
  assign wr_en = ce && psel && penable && pwrite;
  assign rd_en = psel && !penable && !pwrite;

  // ----------------------------------------------------------------
  // register strobes
  // ----------------------------------------------------------------
  // a write lands on the access edge; a read is decoded on the setup edge
  // so the captured word stands for the whole access phase
  assign ctrl_wr = wr_en && lifd_reg_hit(paddr, LIFD_CTRL_ADDR);
  assign recv_rd = rd_en && lifd_reg_hit(paddr, LIFD_RECV_ADDR);

  // ----------------------------------------------------------------
  // address decode and status
  // ----------------------------------------------------------------
  assign ctrl_addr_match = (bus_addr == addr_switches) && (bus_mode == LIFD_MODE_MATCH);
  // the controller's reset term holds status off as well as the local reset
  assign reset_combined_n = !ctrl_reset_term && presetn;
  assign status_en_n = !(ctrl_addr_match && unit_addr_sel && reset_combined_n);
  assign func_active = func_strobe && ctrl_addr_match && unit_addr_sel;
  always_comb begin
    xmit_func = func_active && addr_line_fifteen_buf && !addr_line_fourteen_buf;
    dataset_off_func = func_active && addr_line_fourteen_buf && addr_line_fifteen_buf
                       && !addr_line_twelve_buf;
    send_or_recv_sel = addr_line_thirteen_buf;
    stop_enable_term = func_active && addr_line_fourteen_buf;
    xmit_func_dup = xmit_func;
    dataset_off_func_dup = dataset_off_func;
    stop_enable_term_dup = stop_enable_term;
  end
  assign carry_status_n = carry_in_n;
  assign overflow_status_n = overflow_in_n;
  assign recv_installed = ~recv_present_n;
  assign send_installed = ~send_present_n;
  assign recv_clk_fmt = recv_clk_fmt_in;
  assign send_clk_fmt = send_clk_fmt_in;
  assign one_mhz_clk_buf = one_mhz_clk_in;

  // strobe reaches only the addressed, installed send module
  always_comb begin
    line_send_strobe = 8'h00;
    if (func_strobe && send_enable_term && send_or_recv_sel) begin
      line_send_strobe = send_module_sel & send_installed;
    end
  end

  // ----------------------------------------------------------------
  // receive side
  // ----------------------------------------------------------------
  assign shift_up_detect = recv_data_in[0] && recv_data_in[1] && !recv_data_in[2]
                           && recv_data_in[3] && recv_data_in[4];
  // a request low at an edge captures the character; a new request in the
  // same cycle as the read wins, so a back-to-back character is never lost
  always_comb begin
    next_pending = recv_service_pending;
    next_recv_data = recv_data_reg;
    if (recv_data_taken) begin
      next_pending = 1'b0;
    end
    if (!recv_service_req_n) begin
      next_recv_data = recv_data_in;
      next_pending = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recv_service_pending <= 1'b0;
      recv_data_reg <= 8'h00;
    end else if (ce) begin
      recv_service_pending <= next_pending;
      recv_data_reg <= next_recv_data;
    end
  end

  // ----------------------------------------------------------------
  // case flop
  // ----------------------------------------------------------------
  // a shift-up that meets the clearing write wins, so no case change is lost
  always_comb begin
    next_case = case_flop;
    if (case_clr_req) begin
      next_case = 1'b0;
    end
    if (!recv_service_req_n && shift_up_detect) begin
      next_case = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      case_flop <= 1'b0;
    end else if (ce) begin
      case_flop <= next_case;
    end
  end

  // ----------------------------------------------------------------
  // long space flag
  // ----------------------------------------------------------------
  // the pulse lasts one clock; it is held until software reads the receive
  // register, and a pulse that meets that read wins
  always_comb begin
    next_lsp = long_space_seen;
    if (recv_rd) begin
      next_lsp = 1'b0;
    end
    if (long_space_pulse) begin
      next_lsp = 1'b1;
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      long_space_seen <= 1'b0;
    end else if (ce) begin
      long_space_seen <= next_lsp;
    end
  end

  // ----------------------------------------------------------------
  // module selects
  // ----------------------------------------------------------------
  // a select only moves while the function is live, so address lines that
  // settle between strobes never reach a module
  always_comb begin
    next_recv_sel = recv_module_sel;
    next_send_sel = send_module_sel;
    if (func_active && !send_or_recv_sel) begin
      next_recv_sel = lifd_onehot(unit_recv_sel, recv_addr, recv_addr_n);
    end
    if (func_active && send_or_recv_sel) begin
      next_send_sel = lifd_onehot(1'b1, send_line_addr, ~send_line_addr);
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recv_module_sel <= 8'h00;
      send_module_sel <= 8'h00;
    end else if (ce) begin
      recv_module_sel <= next_recv_sel;
      send_module_sel <= next_send_sel;
    end
  end

  // ----------------------------------------------------------------
  // send data path: fifo to send lines, loaded on transmit function
  // ----------------------------------------------------------------
  // the fifo decouples the controller's fill rate from the transmit strobes;
  // a transmit with the fifo empty sends nothing and leaves the state idle
  lifd_fifo #(.WIDTH(LIFD_DATA_W), .DEPTH(LIFD_FIFO_DEPTH)) u_fifo (
    .pclk(pclk),
    .presetn(presetn),
    .ce(ce),
    .in_valid(send_data_valid),
    .in_ready(send_data_ready),
    .in_data(send_data_in),
    .out_valid(fifo_out_valid),
    .out_ready(send_ld),
    .out_data(fifo_out_data)
  );
  // one character per transmit function: the state waits in hold until the
  // strobe drops, so a long strobe sends one character, not one per clock
  always_comb begin
    next_st = st;
    send_ld = 1'b0;
    next_send_reg = send_reg;
    case (st)
      LIFD_IDLE: begin
        if (xmit_func && send_or_recv_sel && fifo_out_valid) begin
          send_ld = 1'b1;
          next_send_reg = fifo_out_data;
          next_st = LIFD_SEND;
        end
      end
      LIFD_SEND: begin
        next_st = LIFD_HOLD;
      end
      LIFD_HOLD: begin
        if (!func_strobe) begin
          next_st = LIFD_IDLE;
        end
      end
      default: begin
        next_st = LIFD_IDLE;
      end
    endcase
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st <= LIFD_IDLE;
      send_reg <= 8'h00;
    end else if (ce) begin
      st <= next_st;
      send_reg <= next_send_reg;
    end
  end
  assign send_data_lines = send_reg;
  assign send_data_out_valid = (st != LIFD_IDLE);

  // ----------------------------------------------------------------
  // apb slave
  // ----------------------------------------------------------------
  assign case_clr_req = ctrl_wr && pwdata[LIFD_CTRL_CASE_CLR];
  always_comb begin
    next_addr_switches = addr_switches;
    if (ctrl_wr) begin
      next_addr_switches = pwdata[LIFD_CTRL_SWITCH_LSB +: 8];
    end
    next_prdata = prdata;
    if (rd_en) begin
      case (paddr)
        LIFD_CTRL_ADDR: next_prdata = {24'h000000, addr_switches};
        LIFD_SEND_ADDR: next_prdata = {23'h000000, send_data_out_valid, send_reg};
        LIFD_STAT_ADDR: next_prdata = {25'h0000000, case_flop, recv_service_pending,
                                       long_space_seen, !overflow_in_n, !carry_in_n,
                                       ctrl_addr_match, !status_en_n};
        LIFD_RECV_ADDR: next_prdata = {24'h000000, recv_data_reg};
        LIFD_PRES_ADDR: next_prdata = {16'h0000, send_installed, recv_installed};
        default: next_prdata = 32'h0000_0000;
      endcase
    end
  end
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      addr_switches <= LIFD_CTRL_RESET[7:0];
      prdata <= 32'h0000_0000;
    end else if (ce) begin
      addr_switches <= next_addr_switches;
      prdata <= next_prdata;
    end
  end
endmodule // lifd_top
`default_nettype wire

// ==== tb/lifd_sva.sv ====
`timescale 1ns/100ps
`default_nettype none
module lifd_sva (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic func_strobe,
  input wire logic unit_addr_sel,
  input wire logic [1:0] bus_mode,
  input wire logic addr_line_twelve_buf,
  input wire logic addr_line_thirteen_buf,
  input wire logic addr_line_fourteen_buf,
  input wire logic addr_line_fifteen_buf,
  input wire logic send_enable_term,
  input wire logic [7:0] recv_data_in,
  input wire logic recv_service_req_n,
  input wire logic recv_data_taken,
  input wire logic carry_in_n,
  input wire logic overflow_in_n,
  input wire logic xmit_func,
  input wire logic dataset_off_func,
  input wire logic send_or_recv_sel,
  input wire logic stop_enable_term,
  input wire logic stop_enable_term_dup,
  input wire logic status_en_n,
  input wire logic ctrl_addr_match,
  input wire logic reset_combined_n,
  input wire logic carry_status_n,
  input wire logic overflow_status_n,
  input wire logic case_flop,
  input wire logic recv_service_pending,
  input wire logic [7:0] recv_data_reg,
  input wire logic [7:0] line_send_strobe
);
  logic fa;
  // ---
  // function gating: decode only counts while the strobe is up
  // ---
  assign fa = func_strobe && ctrl_addr_match && unit_addr_sel;
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_xmit_decode: assert property (
    xmit_func == (fa && addr_line_fifteen_buf && !addr_line_fourteen_buf))
    else $error("transmit decode wrong");
  a_dsoff_decode: assert property (
    dataset_off_func == (fa && addr_line_fifteen_buf && addr_line_fourteen_buf
    && !addr_line_twelve_buf)) else $error("dataset off decode wrong");
  a_dir_select: assert property (
    send_or_recv_sel == addr_line_thirteen_buf) else $error("direction select wrong");
  a_stop_term: assert property (
    stop_enable_term == (fa && addr_line_fourteen_buf) && stop_enable_term_dup ==
    stop_enable_term) else $error("stop enable wrong");
  a_status_gate: assert property (
    status_en_n == !(ctrl_addr_match && unit_addr_sel && reset_combined_n))
    else $error("status enable wrong");
  a_status_pass: assert property (
    carry_status_n == carry_in_n && overflow_status_n == overflow_in_n)
    else $error("status bits wrong");
  a_mode_match: assert property (
    ctrl_addr_match |-> bus_mode == 2'h3) else $error("match without mode 3");
  a_recv_capture: assert property (
    !recv_service_req_n |=> recv_service_pending && recv_data_reg == $past(recv_data_in))
    else $error("receive capture wrong");
  a_case_set: assert property (
    !recv_service_req_n && recv_data_in[4:0] == 5'h1b |=> case_flop)
    else $error("shift up missed");
  a_pend_clear: assert property (
    recv_data_taken && recv_service_req_n |=> !recv_service_pending)
    else $error("pending not cleared");
  a_strobe_gate: assert property (
    |line_send_strobe |-> func_strobe && send_enable_term) else $error("stray strobe");
  c_xmit: cover property (xmit_func);
  c_case: cover property ($rose(case_flop));
  c_strobe: cover property (|line_send_strobe);
endmodule // lifd_sva
`default_nettype wire

// ==== tb/lifd_send_model.sv ====
`timescale 1ns/100ps
`default_nettype none
// ---
// send module model: takes one character per rise of valid
// ---
module lifd_send_model (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] send_data_lines,
  input wire logic send_data_out_valid,
  output logic got,
  output logic [7:0] got_data
);
  logic was;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      was <= 1'b0;
      got <= 1'b0;
      got_data <= 8'h00;
    end else begin
      was <= send_data_out_valid;
      got <= send_data_out_valid && !was;
      got_data <= send_data_lines;
    end
  end
endmodule // lifd_send_model
`default_nettype wire

// ==== tb/line_interface_function_decode_tb.sv ====
`timescale 1ns/100ps
`default_nettype none
module line_interface_function_decode_tb;
  import lifd_pkg::*;
  logic pclk, presetn, ce, psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] bus_addr, send_data_in, send_data_lines, recv_data_in, recv_data_reg;
  logic [1:0] bus_mode;
  logic unit_addr_sel, ctrl_reset_term, func_strobe, send_enable_term, unit_recv_sel;
  logic addr_line_twelve_buf, addr_line_thirteen_buf, addr_line_fourteen_buf;
  logic addr_line_fifteen_buf, send_data_valid, send_data_ready, send_data_out_valid;
  logic [2:0] send_line_addr, recv_addr, recv_addr_n;
  logic long_space_pulse, recv_service_req_n, recv_data_taken, carry_in_n, overflow_in_n;
  logic [7:0] recv_present_n, send_present_n, line_send_strobe, recv_module_sel;
  logic [7:0] send_module_sel, recv_installed, send_installed, got_data;
  logic [3:0] recv_clk_fmt_in, send_clk_fmt_in, recv_clk_fmt, send_clk_fmt;
  logic one_mhz_clk_in, one_mhz_clk_buf, xmit_func, xmit_func_dup, dataset_off_func;
  logic dataset_off_func_dup, send_or_recv_sel, stop_enable_term, stop_enable_term_dup;
  logic status_en_n, ctrl_addr_match, reset_combined_n, carry_status_n, overflow_status_n;
  logic shift_up_detect, case_flop, recv_service_pending, long_space_seen, got;
  logic [31:0] eq[$], mq[$];
  logic [7:0] cq[$];
  logic [7:0] sw, d;
  int fails, n_compared;
  lifd_top u_dut (.*);
  lifd_send_model u_far (.*);
  initial begin
    pclk = 1'b0;
    forever #2 pclk = ~pclk;
  end
  // ---
  // shared checks and bus cycles
  // ---
  task automatic chk(input logic [31:0] act, input logic [31:0] exp);
    n_compared++;
    if (act !== exp) begin
      fails++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, act, exp);
    end
  endtask
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] wd);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= wd;
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
    // a free edge keeps back-to-back calls from driving psel twice in one step
    @(posedge pclk);
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] e, input logic [31:0] m);
    eq.push_back(e);
    mq.push_back(m);
    apb(1'b0, a, 32'h0);
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
  endtask
  task automatic close_out;
    $display("compared %0d mismatches %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite) chk(prdata & mq.pop_front(), eq.pop_front());
    if (got) chk(got_data, cq.pop_front());
  end
  initial begin
    #100us;
    fails++;
    close_out;
  end
  initial begin
    void'($urandom(76));
    {psel, penable, pwrite, paddr, pwdata, bus_addr, bus_mode, unit_addr_sel} = '0;
    {ctrl_reset_term, func_strobe, send_enable_term, send_line_addr, recv_addr} = '0;
    {addr_line_twelve_buf, addr_line_thirteen_buf, addr_line_fourteen_buf} = '0;
    {addr_line_fifteen_buf, send_data_in, send_data_valid, recv_data_in} = '0;
    {long_space_pulse, recv_data_taken, recv_clk_fmt_in, send_clk_fmt_in} = '0;
    {recv_addr_n, recv_service_req_n, carry_in_n, overflow_in_n, one_mhz_clk_in} = '1;
    {recv_present_n, send_present_n, unit_recv_sel} = '1;
    presetn = 1'b0;
    ce = 1'b1;
    tick(3);
    presetn <= 1'b1;
    tick(1);
    rd(LIFD_CTRL_ADDR, LIFD_CTRL_RESET, '1);
    rd(12'h014, 32'h0, '1);
    sw = $urandom;
    apb(1'b1, LIFD_CTRL_ADDR, {24'h0, sw});
    bus_addr <= sw;
    bus_mode <= LIFD_MODE_MATCH;
    unit_addr_sel <= 1'b1;
    {carry_in_n, overflow_in_n, recv_present_n, send_present_n} <= $urandom;
    {recv_clk_fmt_in, send_clk_fmt_in, one_mhz_clk_in} <= $urandom;
    tick(2);
    chk(ctrl_addr_match, 1);
    chk(status_en_n, 0);
    chk({carry_status_n, overflow_status_n, recv_installed, send_installed},
      {carry_in_n, overflow_in_n, ~recv_present_n, ~send_present_n});
    chk({recv_clk_fmt, send_clk_fmt, one_mhz_clk_buf},
      {recv_clk_fmt_in, send_clk_fmt_in, one_mhz_clk_in});
    chk({pready, pslverr}, 2'b10);
    ctrl_reset_term <= 1'b1;
    bus_mode <= 2'h2;
    tick(2);
    chk({ctrl_addr_match, status_en_n}, 2'b01);
    ctrl_reset_term <= 1'b0;
    bus_mode <= LIFD_MODE_MATCH;
    $display("match test done");
    for (int i = 0; i < 16; i++) begin
      {func_strobe, addr_line_fifteen_buf, addr_line_fourteen_buf, addr_line_twelve_buf} <= i;
      tick(2);
      chk({xmit_func, xmit_func_dup}, {2{i[3] && i[2] && !i[1]}});
      chk({dataset_off_func, dataset_off_func_dup}, {2{i[3] && i[2] && i[1] && !i[0]}});
      chk({stop_enable_term, stop_enable_term_dup}, {2{i[3] && i[1]}});
    end
    $display("decode test done");
    {unit_recv_sel, recv_addr, recv_addr_n, func_strobe} <= {1'b1, 3'h5, 3'h2, 1'b1};
    tick(1);
    func_strobe <= 1'b0;
    tick(2);
    chk(recv_module_sel, 8'h20);
    d = {$urandom, 5'h1b};
    recv_data_in <= d;
    recv_service_req_n <= 1'b0;
    tick(1);
    chk(shift_up_detect, 1);
    recv_service_req_n <= 1'b1;
    tick(1);
    rd(LIFD_RECV_ADDR, {24'h0, d}, 32'hff);
    rd(LIFD_STAT_ADDR, 32'h60, 32'h60);
    recv_data_taken <= 1'b1;
    tick(1);
    recv_data_taken <= 1'b0;
    apb(1'b1, LIFD_CTRL_ADDR, {23'h0, 1'b1, sw});
    recv_data_in <= d ^ 8'h04;
    recv_service_req_n <= 1'b0;
    long_space_pulse <= 1'b1;
    tick(1);
    chk(shift_up_detect, 0);
    {recv_service_req_n, long_space_pulse} <= 2'b10;
    tick(1);
    rd(LIFD_STAT_ADDR, 32'h30, 32'h70);
    rd(LIFD_RECV_ADDR, {24'h0, d ^ 8'h04}, 32'hff);
    rd(LIFD_STAT_ADDR, 32'h20, 32'h70);
    $display("receive test done");
    for (int i = 0; i < LIFD_FIFO_DEPTH; i++) begin
      d = $urandom;
      cq.push_back(d);
      send_data_in <= d;
      send_data_valid <= 1'b1;
      tick(1);
    end
    send_data_valid <= 1'b0;
    tick(1);
    chk(send_data_ready, 0);
    {addr_line_fifteen_buf, addr_line_fourteen_buf, addr_line_thirteen_buf} <= 3'b101;
    {send_line_addr, send_present_n, send_enable_term} <= {3'h3, 8'hf7, 1'b1};
    for (int i = 0; i < LIFD_FIFO_DEPTH; i++) begin
      func_strobe <= 1'b1;
      tick(3);
      chk(line_send_strobe, 8'h08);
      func_strobe <= 1'b0;
      tick(2);
    end
    chk({send_data_ready, 31'(cq.size())}, 32'h8000_0000);
    $display("send test done");
    tick(4);
    close_out;
  end
endmodule // line_interface_function_decode_tb
bind lifd_top lifd_sva u_sva (.*);
`default_nettype wire
